// *** inc/rsse_pkg.sv ***
package rsse_pkg;
   // instruction word layout
   localparam int RSSE_INSTR_W = 12;
   localparam int RSSE_DATA_W = 8;
   localparam int RSSE_ADDR_W = 5;
   localparam int RSSE_ADDR_LSB = 0; // file address field position
   localparam int RSSE_DEST_BIT = 5; // destination select position
   // opcode patterns: top six bits for byte-oriented operations
   localparam logic [5:0] RSSE_OP_ROT_LEFT = 6'h0d;  // 0011 01
   localparam logic [5:0] RSSE_OP_ROT_RIGHT = 6'h0c; // 0011 00
   localparam logic [5:0] RSSE_OP_SUB = 6'h02;       // 0000 10
   localparam logic [11:0] RSSE_OP_SLEEP = 12'h003;  // 0000 0000 0011
   // oscillator periods per instruction cycle
   localparam int RSSE_OSC_PER_CYC = 4;
   localparam logic [1:0] RSSE_PHASE_LAST = 2'h3;
   // reset values of status bits
   localparam logic RSSE_EXPIRY_RST = 1'b1;
   localparam logic RSSE_PDOWN_RST = 1'b1;
   // watchdog counter width
   localparam int RSSE_WDOG_W = 8;
   localparam int RSSE_PRESC_W = 8;

   // operation selected by the decoder
   typedef enum logic [2:0] {
      RSSE_NONE,
      RSSE_RLEFT,
      RSSE_RRIGHT,
      RSSE_SUBF,
      RSSE_SLEEPI
   } rsse_op_t;
endpackage

// *** sim/rsse_exec_props.sv ***
`timescale 1ns/1ns
// port-level watcher for the execution block
module rsse_exec_props
   import rsse_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [11:0] instr,
   input wire logic [7:0] file_rdata,
   input wire logic [4:0] file_addr,
   input wire logic [7:0] file_wdata,
   input wire logic file_we,
   input wire logic [7:0] acc,
   input wire logic carry,
   input wire logic zero,
   input wire logic watchdog_expiry_flag,
   input wire logic power_down_flag,
   input wire logic [7:0] watchdog_counter,
   input wire logic [7:0] wdog_prescaler,
   input wire logic fetch_halt,
   input wire logic cycle_done
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // sleep effects must be visible on the first halted cycle
   a_sleep_sets_expiry: assert property (
      $rose(fetch_halt) |-> watchdog_expiry_flag) else $error("expiry low");
   a_sleep_clears_pdown: assert property (
      $rose(fetch_halt) |-> !power_down_flag) else $error("pdown high");
   a_sleep_clears_wdog: assert property (
      $rose(fetch_halt) |-> watchdog_counter == 8'h0
      && wdog_prescaler == 8'h0) else $error("watchdog not cleared");
   // one instruction per four clocks
   a_done_spacing: assert property (
      cycle_done |=> (!cycle_done) [*3]) else $error("done too soon");
   // results checked against operands seen at the taking edge
   a_rotl_result: assert property (
      file_we && $past(instr[11:6]) == RSSE_OP_ROT_LEFT |->
      file_wdata == {$past(file_rdata[6:0]), $past(carry)} && $stable(acc)
      && carry == $past(file_rdata[7])) else $error("rotate left bad");
   a_rotr_result: assert property (
      file_we && $past(instr[11:6]) == RSSE_OP_ROT_RIGHT |->
      file_wdata == {$past(carry), $past(file_rdata[7:1])} && $stable(acc)
      && carry == $past(file_rdata[0])) else $error("rotate right bad");
   a_sub_flags: assert property (
      cycle_done && $past(instr[11:6]) == RSSE_OP_SUB |->
      zero == ($past(file_rdata) == $past(acc))
      && carry == ($past(file_rdata) >= $past(acc))) else $error("sub flags");
   a_write_addr: assert property (
      file_we |-> file_addr == $past(instr[4:0])) else $error("bad address");
   c_sleep: cover property ($rose(fetch_halt));
   c_file_write: cover property (file_we);
   c_acc_only: cover property (cycle_done && !file_we);
endmodule // rsse_exec_props

bind rsse_exec rsse_exec_props props (
   .clock(clock),
   .rst_n(rst_n),
   .instr(instr),
   .file_rdata(file_rdata),
   .file_addr(file_addr),
   .file_wdata(file_wdata),
   .file_we(file_we),
   .acc(acc),
   .carry(carry),
   .zero(zero),
   .watchdog_expiry_flag(watchdog_expiry_flag),
   .power_down_flag(power_down_flag),
   .watchdog_counter(watchdog_counter),
   .wdog_prescaler(wdog_prescaler),
   .fetch_halt(fetch_halt),
   .cycle_done(cycle_done)
);

// *** sim/rsse_exec_tb.sv ***
`timescale 1ns/1ns
module rsse_exec_tb;
   import rsse_pkg::*;
   logic clock, rst_n, instr_valid, wake, pin_change_wake_flag_in;
   logic wdog_tick = 1'b0; // random prescaler enable
   logic [11:0] instr;
   logic [7:0] mem [32]; // file registers seen by the block
   logic [7:0] file_rdata, acc, file_wdata, watchdog_counter, wdog_prescaler;
   logic [4:0] file_addr;
   logic carry, half_byte_carry, zero, file_we, watchdog_expiry_flag;
   logic power_down_flag, pin_change_wake_flag, fetch_halt, osc_run;
   logic cycle_done;
   logic [30:0] q[$]; // expected results, oldest first
   logic [30:0] got;
   logic [7:0] macc; // model accumulator
   logic mc, mdc, mz, mpd;
   logic [31:0] seed = 32'h2f;
   logic [5:0] ops [3] = '{RSSE_OP_ROT_LEFT, RSSE_OP_ROT_RIGHT, RSSE_OP_SUB};
   int error_cnt, checks, cyc;
   assign file_rdata = mem[instr[4:0]];
   // write data only counts while the strobe is up
   assign got = {acc, file_we, file_we ? {file_addr, file_wdata} : 13'h0,
      carry, half_byte_carry, zero, watchdog_expiry_flag, power_down_flag,
      fetch_halt, osc_run,
      !fetch_halt || (watchdog_counter | wdog_prescaler) == 8'h0,
      pin_change_wake_flag};
   rsse_exec uut (
      .clock(clock),
      .rst_n(rst_n),
      .instr_valid(instr_valid),
      .instr(instr),
      .file_rdata(file_rdata),
      .wake(wake),
      .wdog_tick(wdog_tick),
      .pin_change_wake_flag_in(pin_change_wake_flag_in),
      .file_addr(file_addr),
      .file_wdata(file_wdata),
      .file_we(file_we),
      .acc(acc),
      .carry(carry),
      .half_byte_carry(half_byte_carry),
      .zero(zero),
      .watchdog_expiry_flag(watchdog_expiry_flag),
      .power_down_flag(power_down_flag),
      .pin_change_wake_flag(pin_change_wake_flag),
      .watchdog_counter(watchdog_counter),
      .wdog_prescaler(wdog_prescaler),
      .fetch_halt(fetch_halt),
      .osc_run(osc_run),
      .cycle_done(cycle_done)
   );
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [30:0] e, input logic [30:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic give_verdict();
      $display("checks=%0d error_cnt=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // model one instruction, queue its result, wait for completion
   task automatic issue(input logic [11:0] w);
      logic [7:0] f;
      logic [7:0] r;
      logic [8:0] s;
      logic c;
      int n;
      f = mem[w[4:0]];
      r = macc;
      c = mc;
      case (w[11:6])
         RSSE_OP_ROT_LEFT: {c, r} = {f, mc};
         RSSE_OP_ROT_RIGHT: {r, c} = {mc, f};
         RSSE_OP_SUB: begin
            s = {1'b0, f} - {1'b0, macc};
            r = s[7:0];
            c = !s[8];
            mdc = f[3:0] >= macc[3:0];
            mz = r == 8'h0;
         end
         default: mpd = 1'b0;
      endcase
      q.push_back({w[5] ? macc : r, w[5], w[5] ? {w[4:0], r} : 13'h0, c,
         mdc, mz, 1'b1, mpd, w == RSSE_OP_SLEEP, w != RSSE_OP_SLEEP, 1'b1,
         pin_change_wake_flag_in});
      @(posedge clock);
      instr <= w;
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (cycle_done !== 1'b1 && n < 8);
      macc = w[5] ? macc : r;
      mc = c;
      if (w[5]) mem[w[4:0]] = r;
      // a halted core only resumes on the wake line
      if (w == RSSE_OP_SLEEP) begin
         @(posedge clock);
         wake <= 1'b1;
         // flag pin moves while asleep; sleep must not freeze it
         pin_change_wake_flag_in <= ~pin_change_wake_flag_in;
         while (fetch_halt !== 1'b0 && n++ < 20) @(negedge clock);
         @(posedge clock);
         wake <= 1'b0;
      end
   endtask
   // result watcher, sampled mid-cycle where outputs are settled
   always @(negedge clock) begin
      if (cycle_done === 1'b1) begin
         chk(q.size() ? q.pop_front() : ~got, got);
      end
   end
   // random watchdog ticks and a hang limit
   always @(posedge clock) begin
      wdog_tick <= 1'(rnd());
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         give_verdict();
      end
   end
   initial begin
      rst_n = 1'b0;
      instr_valid = 1'b1;
      instr = 12'h0;
      wake = 1'b0;
      {macc, mc, mdc, mz, mpd} = 12'h1;
      foreach (mem[i]) mem[i] = 8'(rnd());
      pin_change_wake_flag_in = seed[3];
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      for (int i = 0; i < 48; i++) begin
         if (i % 16 == 15) issue(RSSE_OP_SLEEP);
         else issue({ops[rnd() % 3], 6'(rnd())});
      end
      // a withheld word must not execute: any done now finds no note
      @(posedge clock);
      instr_valid <= 1'b0;
      repeat (8) @(posedge clock);
      if (q.size() != 0) error_cnt++;
      give_verdict();
   end
endmodule // rsse_exec_tb

// *** src/rsse_exec.sv ***
`timescale 1ns/1ns
// Notes on behaviour
// - rotate left: carry into bit0, bit7 out
// - rotate left dest bit selects acc/file
// - rotate right: carry into bit7, bit0 out
// - rotate right dest bit selects acc/file
// - sleep sets watchdog expiry flag
// - sleep clears power down flag
// - sleep clears watchdog counter and prescaler
// - address low five bits, dest above
// - four periods per cycle, one cycle each
module rsse_exec (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic instr_valid,
   input wire logic [rsse_pkg::RSSE_INSTR_W-1:0] instr,
   input wire logic [rsse_pkg::RSSE_DATA_W-1:0] file_rdata,
   input wire logic wake,
   input wire logic wdog_tick,
   input wire logic pin_change_wake_flag_in,
   output logic [rsse_pkg::RSSE_ADDR_W-1:0] file_addr,
   output logic [rsse_pkg::RSSE_DATA_W-1:0] file_wdata,
   output logic file_we,
   output logic [rsse_pkg::RSSE_DATA_W-1:0] acc,
   output logic carry,
   output logic half_byte_carry,
   output logic zero,
   output logic watchdog_expiry_flag,
   output logic power_down_flag,
   output logic pin_change_wake_flag,
   output logic [rsse_pkg::RSSE_WDOG_W-1:0] watchdog_counter,
   output logic [rsse_pkg::RSSE_PRESC_W-1:0] wdog_prescaler,
   output logic fetch_halt,
   output logic osc_run,
   output logic cycle_done
);
   import rsse_pkg::*;

   // decode an instruction word into an operation
   function automatic rsse_op_t rsse_decode(
      input logic [RSSE_INSTR_W-1:0] w);
      rsse_op_t op;
      op = RSSE_NONE;
      if (w == RSSE_OP_SLEEP) begin
         op = RSSE_SLEEPI;
      end else if (w[11:6] == RSSE_OP_ROT_LEFT) begin
         op = RSSE_RLEFT;
      end else if (w[11:6] == RSSE_OP_ROT_RIGHT) begin
         op = RSSE_RRIGHT;
      end else if (w[11:6] == RSSE_OP_SUB) begin
         op = RSSE_SUBF;
      end
      return op;
   endfunction

   // block state apart from the pin synchronisers
   typedef struct packed {
      logic [RSSE_ADDR_W-1:0] addr;
      logic [RSSE_DATA_W-1:0] wdata;
      logic we;
      logic [RSSE_DATA_W-1:0] acc;
      logic c;
      logic dc;
      logic z;
      logic expiry;
      logic pdown;
      logic wakef;
      logic [RSSE_WDOG_W-1:0] wdog;
      logic [RSSE_PRESC_W-1:0] presc;
      logic halt;
      logic run; // oscillator enable, kept as its own flop
      logic done;
   } rsse_st_t;

   rsse_st_t s_q, s_d;
   logic cyc_en; // one pulse per instruction cycle
   logic wake_s1_q, wake_s2_q; // wake pin synchroniser
   logic pcw_s1_q, pcw_s2_q; // wake flag pin synchroniser

   // instruction-cycle pacing; oscillator stops in sleep
   rsse_phase u_phase (
      .clock(clock),
      .rst_n(rst_n),
      .run(!s_q.halt),
      .cycle_en(cyc_en)
   );

   // pins from outside the clock domain
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wake_s1_q <= 1'b0;
         wake_s2_q <= 1'b0;
         pcw_s1_q <= 1'b0;
         pcw_s2_q <= 1'b0;
      end else begin
         wake_s1_q <= wake;
         wake_s2_q <= wake_s1_q;
         pcw_s1_q <= pin_change_wake_flag_in;
         pcw_s2_q <= pcw_s1_q;
      end
   end

   // execute one instruction per cycle pulse
   always_comb begin
      rsse_op_t op;
      logic dest_file;
      logic [RSSE_DATA_W-1:0] src;
      logic [RSSE_DATA_W-1:0] res;
      logic [RSSE_DATA_W:0] diff;
      logic [4:0] ldiff;
      op = rsse_decode(instr);
      dest_file = instr[RSSE_DEST_BIT];
      src = file_rdata;
      res = '0;
      diff = '0;
      ldiff = '0;
      s_d = s_q;
      s_d.we = 1'b0;
      s_d.done = 1'b0;
      // wake flag simply follows its source; sleep never writes it
      s_d.wakef = pcw_s2_q;
      // watchdog prescaler keeps time while not cleared
      if (wdog_tick) begin
         s_d.presc = s_q.presc + 8'h01;
         if (s_q.presc == 8'hff) begin
            s_d.wdog = s_q.wdog + 8'h01;
         end
      end
      if (s_q.halt) begin
         // leave sleep only on a synchronised wake event
         if (wake_s2_q) begin
            s_d.halt = 1'b0;
         end
      end else if (cyc_en && instr_valid) begin
         s_d.addr = instr[RSSE_ADDR_LSB +: RSSE_ADDR_W];
         s_d.done = 1'b1;
         case (op)
            RSSE_RLEFT: begin
               res = {src[6:0], s_q.c};
               s_d.c = src[7];
            end
            RSSE_RRIGHT: begin
               res = {s_q.c, src[7:1]};
               s_d.c = src[0];
            end
            RSSE_SUBF: begin
               // file plus two's complement of acc; carry out is no-borrow
               diff = {1'b0, src} + {1'b0, ~s_q.acc} + 9'h001;
               ldiff = {1'b0, src[3:0]} + {1'b0, ~s_q.acc[3:0]} + 5'h01;
               res = diff[7:0];
               s_d.c = diff[8];
               s_d.dc = ldiff[4];
               s_d.z = (diff[7:0] == 8'h00);
            end
            RSSE_SLEEPI: begin
               s_d.expiry = 1'b1;
               s_d.pdown = 1'b0;
               s_d.wdog = '0;
               s_d.presc = '0;
               s_d.halt = 1'b1;
            end
            default: begin
               // other opcodes belong to the rest of the core
            end
         endcase
         // route result for the three data operations
         if (op == RSSE_RLEFT || op == RSSE_RRIGHT || op == RSSE_SUBF) begin
            if (dest_file) begin
               s_d.wdata = res;
               s_d.we = 1'b1;
            end else begin
               s_d.acc = res;
            end
         end
      end
      // registered so the pin is a flop, not an inverter on halt
      s_d.run = !s_d.halt;
   end

   // state register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.expiry <= RSSE_EXPIRY_RST;
         s_q.pdown <= RSSE_PDOWN_RST;
         s_q.run <= 1'b1; // oscillator runs out of reset
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state flops
   assign file_addr = s_q.addr;
   assign file_wdata = s_q.wdata;
   assign file_we = s_q.we;
   assign acc = s_q.acc;
   assign carry = s_q.c;
   assign half_byte_carry = s_q.dc;
   assign zero = s_q.z;
   assign watchdog_expiry_flag = s_q.expiry;
   assign power_down_flag = s_q.pdown;
   assign pin_change_wake_flag = s_q.wakef;
   assign watchdog_counter = s_q.wdog;
   assign wdog_prescaler = s_q.presc;
   assign fetch_halt = s_q.halt;
   assign osc_run = s_q.run;
   assign cycle_done = s_q.done;
endmodule // rsse_exec

// *** src/rsse_phase.sv ***
`timescale 1ns/1ns
// four-phase divider: one pulse per instruction cycle
module rsse_phase (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic run,
   output logic cycle_en
);
   import rsse_pkg::*;

   typedef struct packed {
      logic [1:0] phase; // oscillator period within the cycle
      logic en;          // registered end-of-cycle pulse
   } rsse_phase_st_t;

   rsse_phase_st_t s_q, s_d;

   // next state: count while running, pulse on the last phase
   always_comb begin
      s_d = s_q;
      s_d.en = 1'b0;
      if (run) begin
         s_d.phase = s_q.phase + 2'h1;
         s_d.en = (s_q.phase == RSSE_PHASE_LAST - 2'h1);
      end else begin
         // stopped oscillator: hold at phase zero
         s_d.phase = 2'h0;
      end
   end

   // state register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign cycle_en = s_q.en;
endmodule // rsse_phase
